/* File: rtl/les_cfg.svh */
// Register indices, field positions, reset and preset values of the regulator enable sequencer.
`ifndef LES_CFG_SVH
`define LES_CFG_SVH
`define LES_IDX_ENA 10'h00D
`define LES_IDX_ENA_ALIAS 10'h0B0
`define LES_IDX_SLOT1 10'h0C9
`define LES_IDX_SLOT2 10'h0CC
`define LES_IDX_SLOT3 10'h0CF
`define LES_IDX_SLOT4 10'h0D2
`define LES_IDX_STATUS 10'h0E0
`define LES_ENA_LSB 8
`define LES_SU_LSB 10
`define LES_SD_LSB 6
`define LES_SLOT_NEVER 4'h0
`define LES_SLOT_ENTRY 4'hF
`define LES_ENA_RST 4'h0
`define LES_SLOT_RST 16'h0000
`define LES_MODE_DEV 2'h0
`define LES_PRESET_SU 16'h4321
`define LES_PRESET_SD 16'h1234
`define LES_RESP_OKAY 2'h0
`define LES_RESP_SLVERR 2'h2
`endif

/* File: rtl/les_pkg.sv */
// Types shared by the regulator enable sequencer and its users.
package les_pkg;
   typedef enum logic [1:0] {LES_OFF, LES_PRE, LES_ACT, LES_SHD} les_pwr_t;
   typedef struct packed {
      les_pwr_t pwr;
      logic strobe;
      logic [3:0] slot;
      logic [3:0] block;
   } les_seq_in_t;
   typedef struct packed {
      logic aw_ok;
      logic [9:0] aw_idx;
      logic w_ok;
      logic [15:0] wd;
      logic [1:0] ws;
      logic bv;
      logic be;
      logic rv;
      logic re;
      logic [15:0] rd;
      logic [3:0] ena;
      logic [15:0] su;
      logic [15:0] sd;
      logic [3:0] sq;
      logic [3:0] on;
      les_pwr_t prev;
   } les_state_t;
endpackage : les_pkg

/* File: rtl/les_seq.sv */
// Enable and slot sequencing of four regulators with an AXI4-Lite register slave.
// Operation
// - In the running state each regulator follows its software enable request bit directly.
// - A request written before the running state is stored but turns nothing on until running.
// - When the start-up sequence switches a regulator on, its enable request bit is set to one.
// - Start-up slot field: zero never starts, one to fourteen starts in that slot, all ones on running entry.
// - Shutdown slot field: one to fourteen stops in that slot, zero or all ones stops on off entry.
// - The four enable request bits at bits 8 to 11 are reached identically through two addresses.
// - A set request may be blocked internally, and the actual on state is reported on its own.
// - Preset configuration modes force fixed slot values; programmed slots apply in development mode.
`timescale 1ns/1ps
`include "les_cfg.svh"
module les_seq (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic [1:0] config_mode,
   input wire les_pkg::les_seq_in_t seq_in,
   output logic [3:0] ldo_on
);
   import les_pkg::*;

   les_state_t st_ff;
   les_state_t nxt_st;
   logic [15:0] eff_su;
   logic [15:0] eff_sd;
   logic [3:0] hw_set;
   logic [3:0] sd_hit;
   logic in_pre;
   logic in_act;
   logic in_shd;
   logic act_entry;
   logic off_entry;
   logic wr_go;
   logic [2:0] wr_sel;
   logic [2:0] rd_sel;

   // Decodes a word index into 0 enable, 1 to 4 slot registers, 5 status, 7 unmapped.
   function automatic logic [2:0] les_dec(input logic [9:0] idx);
      logic [2:0] sel;
      sel = 3'h7;
      if (idx == `LES_IDX_ENA || idx == `LES_IDX_ENA_ALIAS)
      begin
         sel = 3'h0;
      end
      else if (idx == `LES_IDX_SLOT1)
      begin
         sel = 3'h1;
      end
      else if (idx == `LES_IDX_SLOT2)
      begin
         sel = 3'h2;
      end
      else if (idx == `LES_IDX_SLOT3)
      begin
         sel = 3'h3;
      end
      else if (idx == `LES_IDX_SLOT4)
      begin
         sel = 3'h4;
      end
      else if (idx == `LES_IDX_STATUS)
      begin
         sel = 3'h5;
      end
      return sel;
   endfunction : les_dec

   // Preset modes ignore stored slot values but keep them, so a later switch to development mode restores them.
   assign eff_su = (config_mode == `LES_MODE_DEV) ? st_ff.su : `LES_PRESET_SU;
   assign eff_sd = (config_mode == `LES_MODE_DEV) ? st_ff.sd : `LES_PRESET_SD;

   assign in_pre = (seq_in.pwr == LES_PRE);
   assign in_act = (seq_in.pwr == LES_ACT);
   assign in_shd = (seq_in.pwr == LES_SHD);
   assign act_entry = in_act && (st_ff.prev != LES_ACT);
   assign off_entry = (seq_in.pwr == LES_OFF) && (st_ff.prev != LES_OFF);

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_reg
         logic [3:0] su_i;
         logic [3:0] sd_i;
         logic su_num;
         logic sd_num;
         assign su_i = eff_su[4 * gi +: 4];
         assign sd_i = eff_sd[4 * gi +: 4];
         assign su_num = (su_i != `LES_SLOT_NEVER) && (su_i != `LES_SLOT_ENTRY);
         assign sd_num = (sd_i != `LES_SLOT_NEVER) && (sd_i != `LES_SLOT_ENTRY);
         // Numbered slots switch on the strobe whose slot number matches.
         assign hw_set[gi] = (in_pre && seq_in.strobe && su_num && seq_in.slot == su_i)
            || (act_entry && su_i == `LES_SLOT_ENTRY);
         assign sd_hit[gi] = in_shd && seq_in.strobe && sd_num && seq_in.slot == sd_i;
      end
   endgenerate

   assign wr_go = st_ff.aw_ok && st_ff.w_ok;
   assign wr_sel = les_dec(st_ff.aw_idx);
   assign rd_sel = les_dec(araddr[11:2]);

   assign awready = !st_ff.aw_ok && !st_ff.bv;
   assign wready = !st_ff.w_ok && !st_ff.bv;
   assign arready = !st_ff.rv;
   assign bvalid = st_ff.bv;
   assign bresp = st_ff.be ? `LES_RESP_SLVERR : `LES_RESP_OKAY;
   assign rvalid = st_ff.rv;
   assign rdata = {16'h0000, st_ff.rd};
   assign rresp = st_ff.re ? `LES_RESP_SLVERR : `LES_RESP_OKAY;
   assign ldo_on = st_ff.on;

   always_comb
   begin
      logic [15:0] mask;
      logic [15:0] old;
      logic [15:0] upd;
      logic [3:0] ena_w;
      nxt_st = st_ff;
      mask = {{8{st_ff.ws[1]}}, {8{st_ff.ws[0]}}};
      old = 16'h0000;
      upd = 16'h0000;
      ena_w = st_ff.ena;
      if (awvalid && awready)
      begin
         nxt_st.aw_ok = 1'b1;
         nxt_st.aw_idx = awaddr[11:2];
      end
      if (wvalid && wready)
      begin
         nxt_st.w_ok = 1'b1;
         nxt_st.wd = wdata[15:0];
         nxt_st.ws = wstrb[1:0];
      end
      if (st_ff.bv && bready)
      begin
         nxt_st.bv = 1'b0;
      end
      if (wr_go)
      begin
         nxt_st.aw_ok = 1'b0;
         nxt_st.w_ok = 1'b0;
         nxt_st.bv = 1'b1;
         nxt_st.be = (wr_sel > 3'h4);
         if (wr_sel == 3'h0)
         begin
            // Both addresses land on the same four bits.
            old = {4'h0, st_ff.ena, 8'h00};
            upd = (old & ~mask) | (st_ff.wd & mask);
            ena_w = upd[`LES_ENA_LSB +: 4];
         end
         else if (wr_sel <= 3'h4)
         begin
            old = {2'b00, st_ff.su[4 * (wr_sel - 3'h1) +: 4], st_ff.sd[4 * (wr_sel - 3'h1) +: 4], 6'h00};
            upd = (old & ~mask) | (st_ff.wd & mask);
            nxt_st.su[4 * (wr_sel - 3'h1) +: 4] = upd[`LES_SU_LSB +: 4];
            nxt_st.sd[4 * (wr_sel - 3'h1) +: 4] = upd[`LES_SD_LSB +: 4];
         end
      end
      // A sequencer set lands on top of a software write in the same cycle.
      nxt_st.ena = ena_w | hw_set;
      if (off_entry)
      begin
         nxt_st.ena = `LES_ENA_RST;
      end
      // The actual on state follows the request only while running.
      unique case (seq_in.pwr)
         LES_OFF:
         begin
            nxt_st.sq = 4'h0;
         end
         LES_PRE:
         begin
            nxt_st.sq = st_ff.sq | hw_set;
         end
         LES_ACT:
         begin
            nxt_st.sq = nxt_st.ena;
         end
         LES_SHD:
         begin
            nxt_st.sq = st_ff.sq & ~sd_hit;
         end
      endcase
      nxt_st.on = nxt_st.sq & ~seq_in.block;
      nxt_st.prev = seq_in.pwr;
      if (st_ff.rv && rready)
      begin
         nxt_st.rv = 1'b0;
      end
      if (arvalid && arready)
      begin
         nxt_st.rv = 1'b1;
         nxt_st.re = (rd_sel > 3'h5);
         nxt_st.rd = 16'h0000;
         if (rd_sel == 3'h0)
         begin
            nxt_st.rd = {4'h0, st_ff.ena, 8'h00};
         end
         else if (rd_sel <= 3'h4)
         begin
            nxt_st.rd = {2'b00, eff_su[4 * (rd_sel - 3'h1) +: 4], eff_sd[4 * (rd_sel - 3'h1) +: 4], 6'h00};
         end
         else if (rd_sel == 3'h5)
         begin
            nxt_st.rd = {12'h000, st_ff.on};
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   default clocking les_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence running_two_s;
      in_act ##1 in_act;
   endsequence

   sequence slot1_strobe_s;
      in_pre && seq_in.strobe && eff_su[3:0] == seq_in.slot && eff_su[3:0] != `LES_SLOT_NEVER
         && eff_su[3:0] != `LES_SLOT_ENTRY;
   endsequence

   run_follow_a: assert property (running_two_s |-> ldo_on == (st_ff.ena & ~$past(seq_in.block)))
      else $error("Regulators do not follow their requests while running.");

   pre_hold_a: assert property ((in_pre && st_ff.sq == 4'h0 && hw_set == 4'h0) |=> ldo_on == 4'h0)
      else $error("A regulator came on before its start-up slot.");

   slot_set_a: assert property (slot1_strobe_s |=> st_ff.ena[0] && (ldo_on[0] || $past(seq_in.block[0])))
      else $error("Start-up slot did not set and switch on regulator one.");

   entry_start_a: assert property ((act_entry && eff_su[11:8] == `LES_SLOT_ENTRY) |=> st_ff.ena[2])
      else $error("Running entry did not start a regulator marked for it.");

   never_start_a: assert property ((in_pre && eff_su[3:0] == `LES_SLOT_NEVER && st_ff.sq[0] == 1'b0)
      |=> st_ff.sq[0] == 1'b0)
      else $error("A regulator with start slot zero was started.");

   sd_slot_a: assert property ((in_shd && seq_in.strobe && seq_in.slot == eff_sd[3:0]
      && eff_sd[3:0] != `LES_SLOT_NEVER && eff_sd[3:0] != `LES_SLOT_ENTRY) |=> !ldo_on[0] [*2])
      else $error("Shutdown slot did not switch regulator one off.");

   off_state_a: assert property ((seq_in.pwr == LES_OFF) |=> ldo_on == 4'h0)
      else $error("A regulator is on in the off state.");

   ena_write_a: assert property ((wr_go && wr_sel == 3'h0 && st_ff.ws[1] && !off_entry)
      |=> st_ff.ena == ($past(st_ff.wd[11:8]) | $past(hw_set)))
      else $error("Enable request write through either address failed.");

   block_gate_a: assert property (seq_in.block[0] |=> !ldo_on[0])
      else $error("A blocked regulator reports on.");

   preset_a: assert property ((config_mode != `LES_MODE_DEV)
      |-> eff_su == `LES_PRESET_SU && eff_sd == `LES_PRESET_SD)
      else $error("Preset mode does not force the slot values.");

   bresp_a: assert property ((wr_go && wr_sel == 3'h7) |=> bvalid && bresp == `LES_RESP_SLVERR)
      else $error("Unmapped write was not answered with an error.");

   // Ready is withdrawn while an answer waits, so the bus never holds two answers of one kind.
   sequence ar_take_s;
      arvalid && arready;
   endsequence

   write_answer_a: assert property (wr_go |=> bvalid)
      else $error("A complete write was not answered in the next cycle.");

   bresp_ok_a: assert property ((wr_go && wr_sel <= 3'h4) |=> bresp == `LES_RESP_OKAY)
      else $error("A mapped write was answered with an error.");

   write_clear_a: assert property ((bvalid && bready) |=> !bvalid)
      else $error("Write answer stayed after it was taken.");

   aw_refuse_a: assert property (bvalid |-> !awready && !wready)
      else $error("Write channels are ready while an answer waits.");

   read_answer_a: assert property (ar_take_s |=> rvalid)
      else $error("A read was not answered in the next cycle.");

   read_clear_a: assert property ((rvalid && rready) |=> !rvalid)
      else $error("Read answer stayed after it was taken.");

   ar_refuse_a: assert property (rvalid |-> !arready)
      else $error("Read address is ready while an answer waits.");

   read_unmapped_a: assert property ((arvalid && arready && rd_sel == 3'h7)
      |=> rvalid && rresp == `LES_RESP_SLVERR && rdata == 32'h00000000)
      else $error("Unmapped read was not answered with an error.");

   ena_read_a: assert property ((arvalid && arready && rd_sel == 3'h0)
      |=> rdata[11:8] == $past(st_ff.ena))
      else $error("Enable request readback differs from the stored bits.");

   status_read_a: assert property ((arvalid && arready && rd_sel == 3'h5)
      |=> rdata[3:0] == $past(ldo_on))
      else $error("Status readback differs from the actual on state.");

   slot_read_a: assert property ((arvalid && arready && rd_sel == 3'h1)
      |=> rdata[13:10] == $past(eff_su[3:0]) && rdata[9:6] == $past(eff_sd[3:0]))
      else $error("Slot readback differs from the effective slot values.");

   pre_store_a: assert property ((in_pre && hw_set == 4'h0) |=> st_ff.sq == $past(st_ff.sq))
      else $error("A regulator changed before running without its start slot.");

   ena_hold_a: assert property ((!wr_go && hw_set == 4'h0 && !off_entry)
      |=> st_ff.ena == $past(st_ff.ena))
      else $error("Enable requests changed with no write and no sequencer set.");

   entry_only_a: assert property ((in_act && !act_entry) |-> hw_set == 4'h0)
      else $error("The sequencer set a request while already running.");

   run_sq_a: assert property (in_act |=> st_ff.sq == st_ff.ena)
      else $error("Running state does not follow the enable requests.");

   sd_keep_a: assert property ((in_shd && !seq_in.strobe) |=> st_ff.sq == $past(st_ff.sq))
      else $error("A regulator changed during shutdown without a slot strobe.");

   off_clear_a: assert property (off_entry |=> st_ff.ena == 4'h0)
      else $error("Entering the off state did not clear the requests.");

endmodule : les_seq

/* File: tb/les_pwr_model.sv */
// Behavioural chip power-state sequencer that drives the sequencer link.
`timescale 1ns/1ps
module les_pwr_model (
   input wire logic aclk,
   output les_pkg::les_seq_in_t seq_in
);
   import les_pkg::*;
   initial
   begin
      seq_in = '0;
   end
   task automatic go(input les_pwr_t p);
      @(posedge aclk);
      seq_in.pwr <= p;
   endtask : go
   // The slot number only means something beside the strobe, so it is scrambled afterwards.
   task automatic step(input logic [3:0] s);
      @(posedge aclk);
      seq_in.strobe <= 1'h1;
      seq_in.slot <= s;
      @(posedge aclk);
      seq_in.strobe <= 1'h0;
      seq_in.slot <= ~s;
   endtask : step
   task automatic blk(input logic [3:0] b);
      @(posedge aclk);
      seq_in.block <= b;
   endtask : blk
endmodule : les_pwr_model

/* File: tb/tb_les_seq.sv */
// Self-checking testbench of the regulator enable sequencer.
`timescale 1ns/1ps
`include "les_cfg.svh"
module tb_les_seq;
   import les_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic awvalid = 1'h0;
   logic wvalid = 1'h0;
   logic bready = 1'h0;
   logic arvalid = 1'h0;
   logic rready = 1'h0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] config_mode = 2'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0] ldo_on;
   les_seq_in_t seq_in;
   int fails = 0;
   int total_checks = 0;
   always #2.5 aclk = ~aclk;
   les_seq u_les_seq (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
      .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
      .config_mode, .seq_in, .ldo_on);
   les_pwr_model u_les_pwr_model (.aclk, .seq_in);
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task tmo(input int n);
      if (n >= 50)
      begin
         fails++;
         $display("wrong value at %0t: bus wait ran out", $time);
         report_and_stop();
      end
   endtask : tmo
   task w(input int n);
      repeat (n) @(posedge aclk);
   endtask : w
   task wr(input logic [9:0] i, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= {i, 2'h0};
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
         n++;
      end while (bvalid !== 1'h1 && n < 50);
      tmo(n);
      chk({30'h0, bresp}, {30'h0, er});
      bready <= 1'h0;
      @(posedge aclk);
   endtask : wr
   task rd(input logic [9:0] i, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= {i, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'h0;
         n++;
      end while (rvalid !== 1'h1 && n < 50);
      tmo(n);
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
      rready <= 1'h0;
      @(posedge aclk);
   endtask : rd
   task t_reset;
      rd(`LES_IDX_ENA, 32'h0, 2'h0);
      rd(`LES_IDX_SLOT1, 32'h0, 2'h0);
      rd(10'h001, 32'h0, 2'h2);
      wr(10'h001, 32'hFFFF, 2'h2);
      $display("test reset done");
   endtask : t_reset
   task t_pre;
      u_les_pwr_model.go(LES_PRE);
      wr(`LES_IDX_ENA_ALIAS, 32'h100, 2'h0);
      w(4);
      chk({28'h0, ldo_on}, 32'h0);
      rd(`LES_IDX_ENA, 32'h100, 2'h0);
      u_les_pwr_model.go(LES_ACT);
      w(4);
      chk({28'h0, ldo_on}, 32'h1);
      u_les_pwr_model.blk(4'h1);
      w(4);
      chk({28'h0, ldo_on}, 32'h0);
      rd(`LES_IDX_STATUS, 32'h0, 2'h0);
      rd(`LES_IDX_ENA_ALIAS, 32'h100, 2'h0);
      u_les_pwr_model.blk(4'h0);
      w(4);
      rd(`LES_IDX_STATUS, 32'h1, 2'h0);
      wr(`LES_IDX_ENA, 32'h0, 2'h0);
      w(4);
      chk({28'h0, ldo_on}, 32'h0);
      // Only the low byte is strobed, so the request bits in the high byte must stay clear.
      wstrb <= 4'h1;
      wr(`LES_IDX_ENA, 32'hF00, 2'h0);
      rd(`LES_IDX_ENA_ALIAS, 32'h0, 2'h0);
      wstrb <= 4'hF;
      $display("test running enable done");
   endtask : t_pre
   task t_slots;
      u_les_pwr_model.go(LES_SHD);
      u_les_pwr_model.go(LES_OFF);
      // Distinct start slots keep the inrush of the two regulators apart.
      wr(`LES_IDX_SLOT2, 32'hD40, 2'h0);
      wr(`LES_IDX_SLOT3, 32'h3C00, 2'h0);
      u_les_pwr_model.go(LES_PRE);
      u_les_pwr_model.step(4'h0);
      w(3);
      chk({28'h0, ldo_on}, 32'h0);
      u_les_pwr_model.step(4'h3);
      w(3);
      chk({28'h0, ldo_on}, 32'h2);
      rd(`LES_IDX_ENA, 32'h200, 2'h0);
      u_les_pwr_model.go(LES_ACT);
      w(4);
      chk({28'h0, ldo_on}, 32'h6);
      rd(`LES_IDX_ENA, 32'h600, 2'h0);
      u_les_pwr_model.go(LES_SHD);
      u_les_pwr_model.step(4'h5);
      w(3);
      chk({28'h0, ldo_on}, 32'h4);
      u_les_pwr_model.go(LES_OFF);
      w(4);
      chk({28'h0, ldo_on}, 32'h0);
      $display("test slot sequencing done");
   endtask : t_slots
   task t_preset;
      config_mode <= 2'h1;
      w(2);
      rd(`LES_IDX_SLOT1, 32'h500, 2'h0);
      rd(`LES_IDX_SLOT3, 32'hC80, 2'h0);
      u_les_pwr_model.go(LES_PRE);
      u_les_pwr_model.step(4'h1);
      w(3);
      chk({28'h0, ldo_on}, 32'h1);
      rd(`LES_IDX_ENA_ALIAS, 32'h100, 2'h0);
      u_les_pwr_model.go(LES_ACT);
      w(4);
      chk({28'h0, ldo_on}, 32'h1);
      u_les_pwr_model.go(LES_SHD);
      u_les_pwr_model.step(4'h4);
      w(3);
      chk({28'h0, ldo_on}, 32'h0);
      u_les_pwr_model.go(LES_OFF);
      config_mode <= 2'h0;
      w(2);
      rd(`LES_IDX_SLOT3, 32'h3C00, 2'h0);
      $display("test preset modes done");
   endtask : t_preset
   initial
   begin
      w(3);
      aresetn <= 1'h1;
      w(1);
      t_reset();
      t_pre();
      t_slots();
      t_preset();
      report_and_stop();
   end
endmodule : tb_les_seq
